// >>> rsm_mode_ctrl.v
// Run/stop mode controller with fatal-fault recovery window and
// serial port protocol selection, APB register slave.
// Assumes synchronous inputs on SYS_CLK, async active-low RST_B.
`timescale 1ns/1ps
`include "rsm_regs.vh"

module rsm_mode_ctrl #(
    parameter WINDOW_CYC   = `RSM_WINDOW_CYC,
    parameter HOLD_CYC     = `RSM_HOLD_CYC,
    parameter DEBOUNCE_CYC = `RSM_DEBOUNCE_CYC,
    parameter BLINK_CYC    = `RSM_BLINK_CYC
) (
    input  wire        SYS_CLK,      // System clock
    input  wire        RST_B,        // Async reset, active low
    input  wire        PSEL,         // APB select
    input  wire        PENABLE,      // APB enable
    input  wire        PWRITE,       // APB direction
    input  wire [11:0] PADDR,        // APB byte address
    input  wire [31:0] PWDATA,       // APB write data
    output reg  [31:0] PRDATA,       // APB read data
    output reg         PREADY,       // APB ready
    output reg         PSLVERR,      // APB error
    input  wire        SWITCH_RUN,   // Mode switch, high = Run
    input  wire        FATAL_FAULT,  // Fatal fault event pulse
    input  wire        MINOR_FAULT,  // Non-fatal fault event pulse
    input  wire        MEM_WR_REQ,   // Memory write/force request
    output reg         MEM_WR_OK,    // Memory write/force permitted
    input  wire [1:0]  PROG_NEED,    // Programmer protocol needed
    output reg  [1:0]  PORT1_PROTO,  // Active protocol, port 1
    output reg  [1:0]  PORT2_PROTO,  // Active protocol, port 2
    input  wire        P1_TX_INT,    // Port 1 transmit from core
    input  wire        P1_RTS_INT,   // Port 1 RTS from core
    output reg         P1_TXD,       // Port 1 transmit data
    output reg         P1_RTS,       // Port 1 request to send
    input  wire        P1_RXD,       // Port 1 receive data
    input  wire        P1_CTS,       // Port 1 clear to send
    output reg         P1_RX_INT,    // Port 1 receive to core
    output reg         P1_CTS_INT,   // Port 1 CTS to core
    output reg         RUN_MODE,     // Controller in Run
    output reg         RUN_LED,      // Run indicator
    output reg         FAULT_LED,    // Fault indicator
    output reg         IRQ           // Interrupt, active high
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam ST_STOP  = 2'h0;
localparam ST_RUN   = 2'h1;
localparam ST_FAULT = 2'h2;
localparam ST_WIN   = 2'h3;

localparam SQ_RUN1  = 2'h0;
localparam SQ_STOP  = 2'h1;
localparam SQ_DONE  = 2'h2;

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg  [3:0]  ctrl;
reg  [5:0]  irq_stat;
reg  [5:0]  irq_mask;
reg  [3:0]  port_cfg;          // [1:0] port 1, [3:2] port 2
reg  [15:0] port_par;          // Serial parameters, kept on revert
reg  [1:0]  state;
reg  [1:0]  seq;
reg         minor_flt;
reg         fatal_flt;
reg         sw_s1;
reg         sw_s2;
reg         sw_db;
reg         sw_db_d;
reg  [31:0] db_cnt;
reg  [31:0] win_cnt;
reg  [31:0] hold_cnt;
reg  [31:0] blink_cnt;
reg         blink;
reg  [5:0]  ev;
reg  [31:0] rd_val;
wire [3:0]  next_proto;        // [1:0] port 1, [3:2] port 2

wire        apb_acc  = PSEL && PENABLE;
wire        apb_wr   = apb_acc && PWRITE;
wire        sw_rise  = sw_db && !sw_db_d;
wire        sw_fall  = !sw_db && sw_db_d;
wire        sw_en    = ctrl[`RSM_CTRL_SWMODE];
wire        clr_flt  = apb_wr && (PADDR == `RSM_CTRL_OFS)
                       && PWDATA[`RSM_CTRL_CLRFLT];
wire        hold_ok  = (hold_cnt >= HOLD_CYC - 1);
wire        win_end  = (win_cnt >= WINDOW_CYC - 1);
wire        running  = (state == ST_RUN);

// ----------------------------------------------------------------
// Switch synchroniser and debounce
// ----------------------------------------------------------------
always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
        sw_s1   <= 1'b0;
        sw_s2   <= 1'b0;
        sw_db   <= 1'b0;
        sw_db_d <= 1'b0;
        db_cnt  <= 32'h0000_0000;
    end else begin
        sw_s1   <= SWITCH_RUN;
        sw_s2   <= sw_s1;
        sw_db_d <= sw_db;
        if (sw_s2 == sw_db)
            db_cnt <= 32'h0000_0000;
        else if (db_cnt >= DEBOUNCE_CYC - 1) begin
            sw_db  <= sw_s2;
            db_cnt <= 32'h0000_0000;
        end else
            db_cnt <= db_cnt + 32'h0000_0001;
    end
end

// ----------------------------------------------------------------
// Mode state machine and recovery sequence
// ----------------------------------------------------------------
always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
        state     <= ST_STOP;
        seq       <= SQ_RUN1;
        win_cnt   <= 32'h0000_0000;
        hold_cnt  <= 32'h0000_0000;
        minor_flt <= 1'b0;
        fatal_flt <= 1'b0;
        ev        <= 6'h00;
    end else begin
        ev <= 6'h00;
        if (sw_rise || sw_fall)
            hold_cnt <= 32'h0000_0000;
        else if (!hold_ok)
            hold_cnt <= hold_cnt + 32'h0000_0001;
        if (MINOR_FAULT)
            minor_flt <= 1'b1;
        else if (clr_flt)
            minor_flt <= 1'b0;
        if (FATAL_FAULT) begin
            fatal_flt <= 1'b1;
            state     <= ST_FAULT;
            ev[`RSM_IRQ_FATAL] <= 1'b1;
        end else begin
            if (clr_flt)
                fatal_flt <= 1'b0;
            case (state)
                ST_STOP: begin
                    if (sw_en && sw_rise) begin
                        state <= ST_RUN;
                        ev[`RSM_IRQ_RUN] <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if ((sw_en && sw_fall) || ctrl[`RSM_CTRL_STOPREQ])
                        state <= ST_STOP;
                end
                ST_FAULT: begin
                    if (!fatal_flt)
                        state <= ST_STOP;
                    else if (sw_en && sw_rise) begin
                        state   <= ST_WIN;
                        seq     <= SQ_RUN1;
                        win_cnt <= 32'h0000_0000;
                        ev[`RSM_IRQ_WINDOW] <= 1'b1;
                    end
                end
                ST_WIN: begin
                    win_cnt <= win_cnt + 32'h0000_0001;
                    case (seq)
                        SQ_RUN1: begin
                            if (sw_fall)
                                seq <= hold_ok ? SQ_STOP : SQ_RUN1;
                        end
                        SQ_STOP: begin
                            if (sw_rise)
                                seq <= hold_ok ? SQ_DONE : SQ_RUN1;
                        end
                        default: seq <= SQ_RUN1;
                    endcase
                    if (seq == SQ_DONE) begin
                        fatal_flt <= 1'b0;
                        minor_flt <= 1'b0;
                        state     <= ST_RUN;
                        ev[`RSM_IRQ_RECOVER] <= 1'b1;
                    end else if (win_end) begin
                        state <= ST_FAULT;
                        ev[`RSM_IRQ_EXPIRE] <= 1'b1;
                    end
                end
                default: state <= ST_STOP;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// Blink divider
// ----------------------------------------------------------------
always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
        blink_cnt <= 32'h0000_0000;
        blink     <= 1'b0;
    end else if (blink_cnt >= BLINK_CYC - 1) begin
        blink_cnt <= 32'h0000_0000;
        blink     <= !blink;
    end else
        blink_cnt <= blink_cnt + 32'h0000_0001;
end

// ----------------------------------------------------------------
// Port protocol selection
// ----------------------------------------------------------------
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
        wire [1:0] cfg_sel = port_cfg[2*gi +: 2];
        assign next_proto[2*gi +: 2] =
            (cfg_sel == `RSM_PROTO_REGACC && !PROG_NEED[gi])
                ? `RSM_PROTO_REGACC
                : (cfg_sel == `RSM_PROTO_SIO && running)
                ? `RSM_PROTO_SIO
                : `RSM_PROTO_PROG;
    end
endgenerate

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
        RUN_MODE    <= 1'b0;
        RUN_LED     <= 1'b0;
        FAULT_LED   <= 1'b0;
        MEM_WR_OK   <= 1'b0;
        PORT1_PROTO <= `RSM_PROTO_PROG;
        PORT2_PROTO <= `RSM_PROTO_PROG;
        P1_TXD      <= 1'b1;
        P1_RTS      <= 1'b0;
        P1_RX_INT   <= 1'b1;
        P1_CTS_INT  <= 1'b0;
        IRQ         <= 1'b0;
    end else begin
        RUN_MODE    <= running;
        RUN_LED     <= running || (state == ST_WIN && blink);
        FAULT_LED   <= fatal_flt;
        MEM_WR_OK   <= MEM_WR_REQ
                       && !(ctrl[`RSM_CTRL_MEMPROT] && !sw_db);
        PORT1_PROTO <= next_proto[1:0];
        PORT2_PROTO <= next_proto[3:2];
        P1_TXD      <= P1_TX_INT;
        P1_RTS      <= P1_RTS_INT;
        P1_RX_INT   <= P1_RXD;
        P1_CTS_INT  <= P1_CTS;
        IRQ         <= |(irq_stat & irq_mask);
    end
end

// ----------------------------------------------------------------
// APB slave
// ----------------------------------------------------------------
always @* begin
    rd_val = 32'h0000_0000;
    case (PADDR)
        `RSM_CTRL_OFS:     rd_val = {28'h0, ctrl};
        `RSM_STAT_OFS:     rd_val = {21'h0, PORT2_PROTO, PORT1_PROTO,
                                     sw_db, minor_flt, fatal_flt,
                                     seq, state};
        `RSM_IRQ_STAT_OFS: rd_val = {26'h0, irq_stat};
        `RSM_IRQ_MASK_OFS: rd_val = {26'h0, irq_mask};
        `RSM_PORT_OFS:     rd_val = {port_par, 12'h0, port_cfg};
        default:           rd_val = 32'h0000_0000;
    endcase
end

always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
        ctrl     <= `RSM_CTRL_RESET;
        irq_stat <= 6'h00;
        irq_mask <= 6'h00;
        port_cfg <= 4'h0;
        port_par <= 16'h0000;
        PRDATA   <= 32'h0000_0000;
        PREADY   <= 1'b0;
        PSLVERR  <= 1'b0;
    end else begin
        PREADY  <= PSEL && !PENABLE;
        PSLVERR <= 1'b0;
        if (PSEL && !PENABLE) begin
            PRDATA  <= rd_val;
            PSLVERR <= (PADDR > `RSM_PORT_OFS) || (PADDR[1:0] != 2'h0);
        end
        if (apb_wr && PREADY) begin
            case (PADDR)
                `RSM_CTRL_OFS:     ctrl <= PWDATA[3:0] & 4'h7;
                `RSM_IRQ_MASK_OFS: irq_mask <= PWDATA[5:0];
                `RSM_PORT_OFS: begin
                    port_cfg <= PWDATA[3:0];
                    port_par <= PWDATA[31:16];
                end
                default: ;
            endcase
        end
        irq_stat <= (apb_wr && PREADY && PADDR == `RSM_IRQ_STAT_OFS)
                    ? ((irq_stat & ~PWDATA[5:0]) | ev) : (irq_stat | ev);
    end
end

endmodule // rsm_mode_ctrl

// >>> rsm_regs.vh
// Register offsets, fields, reset values and timing counts for the
// run/stop mode controller. Assumes a 250 MHz system clock.
`ifndef RSM_REGS_VH
`define RSM_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RSM_CTRL_OFS      12'h000
`define RSM_STAT_OFS      12'h004
`define RSM_IRQ_STAT_OFS  12'h008
`define RSM_IRQ_MASK_OFS  12'h00c
`define RSM_PORT_OFS      12'h010

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define RSM_CTRL_SWMODE   0
`define RSM_CTRL_MEMPROT  1
`define RSM_CTRL_STOPREQ  2
`define RSM_CTRL_CLRFLT   3
`define RSM_CTRL_RESET    4'h1

// ----------------------------------------------------------------
// Port protocol codes
// ----------------------------------------------------------------
`define RSM_PROTO_PROG    2'h0
`define RSM_PROTO_REGACC  2'h1
`define RSM_PROTO_SIO     2'h2

// ----------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------
`define RSM_IRQ_RUN       0
`define RSM_IRQ_WINDOW    1
`define RSM_IRQ_RECOVER   2
`define RSM_IRQ_EXPIRE    3
`define RSM_IRQ_FATAL     4
`define RSM_IRQ_W         5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RSM_CLK_MHZ       250
`define RSM_WINDOW_MS     5000
`define RSM_HOLD_MS       500
`define RSM_DEBOUNCE_US   10
`define RSM_BLINK_MS      250
`define RSM_WINDOW_CYC    (`RSM_WINDOW_MS * 1000 * `RSM_CLK_MHZ)
`define RSM_HOLD_CYC      (`RSM_HOLD_MS * 1000 * `RSM_CLK_MHZ)
`define RSM_DEBOUNCE_CYC  (`RSM_DEBOUNCE_US * `RSM_CLK_MHZ)
`define RSM_BLINK_CYC     (`RSM_BLINK_MS * 1000 * `RSM_CLK_MHZ)

`endif

// >>> rsm_chk.sv
// Port checker for the run/stop mode controller.
// Assumes a bind onto rsm_mode_ctrl with the same BLINK_CYC.
`timescale 1ns/1ps
module rsm_chk #(
    parameter BLINK_CYC = 20
) (
    input wire       SYS_CLK,     // Clock
    input wire       RST_B,       // Reset
    input wire       PSEL,        // Select
    input wire       PENABLE,     // Enable
    input wire       PREADY,      // Ready
    input wire       PSLVERR,     // Error
    input wire       MEM_WR_REQ,  // Write ask
    input wire       MEM_WR_OK,   // Write grant
    input wire [1:0] PROG_NEED,   // Need prog
    input wire [1:0] PORT1_PROTO, // Port 1
    input wire [1:0] PORT2_PROTO, // Port 2
    input wire       P1_TX_INT,   // Tx in
    input wire       P1_TXD,      // Tx pin
    input wire       P1_RXD,      // Rx pin
    input wire       P1_RX_INT,   // Rx out
    input wire       FATAL_FAULT, // Fatal
    input wire       RUN_MODE,    // Run
    input wire       RUN_LED,     // Run lamp
    input wire       FAULT_LED    // Fault lamp
);
    reg [31:0] lit;
    // Length of a lit spell outside Run
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B)
            lit <= 32'h0;
        else
            lit <= (RUN_LED && !RUN_MODE) ? lit + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);
    ready_pulse_a: assert property (PSEL && PENABLE |-> PREADY ##1 !PREADY)
        else $error("ready not a one-cycle answer");
    err_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    wr_gate_a: assert property (
        MEM_WR_OK |-> $past(MEM_WR_REQ))
        else $error("write granted unasked");
    tx_path_a: assert property (
        $past(RST_B) |-> P1_TXD == $past(P1_TX_INT))
        else $error("tx pin lost the core bit");
    rx_path_a: assert property (
        $past(RST_B) |-> P1_RX_INT == $past(P1_RXD))
        else $error("rx pin not passed in");
    fatal_stop_a: assert property (
        FATAL_FAULT |-> ##[1:3] (FAULT_LED && !RUN_MODE))
        else $error("fatal fault not shown");
    proto_stop_a: assert property (
        !RUN_MODE && !$past(RUN_MODE) |->
        PORT1_PROTO != 2'h2 && PORT2_PROTO != 2'h2)
        else $error("serial io kept in stop");
    need_prog_a: assert property (
        $past(PROG_NEED[0]) && $past(PROG_NEED[0], 2) |-> PORT1_PROTO != 2'h1)
        else $error("register access not yielded");
    run_led_a: assert property (
        RUN_MODE && $past(RUN_MODE) |-> RUN_LED)
        else $error("run lamp dark in run");
    blink_half_a: assert property (
        lit <= BLINK_CYC + 1)
        else $error("run lamp not blinking");
endmodule // rsm_chk

// >>> rsm_host_model.sv
// Operator switch and serial host at the controller's far side.
// Assumes one clock; the host echoes port 1 back to the block.
`timescale 1ns/1ps
module rsm_host_model (
    input  wire clk,   // Clock
    input  wire txd,   // Tx from block
    input  wire rts,   // Rts from block
    output reg  rxd,   // Rx into block
    output reg  cts,   // Cts into block
    output reg  sw_run // Switch, high = Run
);
    initial begin
        rxd = 1'b1;
        cts = 1'b0;
        sw_run = 1'b0;
    end
    // Host answers with the line settings it is sent
    always @(posedge clk) begin
        rxd <= txd;
        cts <= rts;
    end
    task move(input logic v, input int n);
        begin
            @(posedge clk);
            sw_run <= v;
            repeat (n) @(posedge clk);
        end
    endtask
endmodule // rsm_host_model

// >>> test_run_stop_mode_control.sv
// Self-checking bench for the run/stop mode controller.
// Assumes rsm_mode_ctrl, rsm_host_model and rsm_chk are compiled.
`timescale 1ns/1ps
`include "rsm_regs.vh"
module test_run_stop_mode_control;
    localparam int WIN = 2000;
    localparam int HOLD = 200;
    logic        sys_clk = 1'b0, rst_b = 1'b0, a;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, mem_ok, txd, rts, rxd, cts, sw;
    logic        fatal = 1'b0, minor = 1'b0, mem_req = 1'b0;
    logic        tx_int = 1'b0, rts_int = 1'b0;
    logic [1:0]  need = 2'h0, p1_proto, p2_proto;
    logic        rx_int, cts_int, run_mode, run_led, fault_led, irq;
    logic [7:0]  lf = 8'h14;
    logic [5:0]  hist = 6'h0;
    int          miscompares = 0, n_checks = 0, cyc = 0;
    rsm_mode_ctrl #(.WINDOW_CYC(WIN), .HOLD_CYC(HOLD), .DEBOUNCE_CYC(4),
        .BLINK_CYC(20)) u_rsm_mode_ctrl (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SWITCH_RUN(sw),
        .FATAL_FAULT(fatal), .MINOR_FAULT(minor), .MEM_WR_REQ(mem_req),
        .MEM_WR_OK(mem_ok), .PROG_NEED(need), .PORT1_PROTO(p1_proto),
        .PORT2_PROTO(p2_proto), .P1_TX_INT(tx_int), .P1_RTS_INT(rts_int),
        .P1_TXD(txd), .P1_RTS(rts), .P1_RXD(rxd), .P1_CTS(cts),
        .P1_RX_INT(rx_int), .P1_CTS_INT(cts_int), .RUN_MODE(run_mode),
        .RUN_LED(run_led), .FAULT_LED(fault_led), .IRQ(irq));
    rsm_host_model u_host (.clk(sys_clk), .txd(txd), .rts(rts), .rxd(rxd),
        .cts(cts), .sw_run(sw));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // One APB transfer, held until ready is sampled
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        lf <= lfsr(lf);
        tx_int <= lf[0];
        rts_int <= lf[3];
        hist <= {hist[3:0], rts_int, tx_int};
        if (rst_b && cyc > 16)
            chk(32'({cts_int, rx_int}), 32'(hist[5:4]));
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        apb(1'b0, `RSM_CTRL_OFS, 32'h0);
        chk(rd, 32'h1 << `RSM_CTRL_SWMODE);
        apb(1'b0, `RSM_PORT_OFS, 32'h0);
        chk(32'({rd[3:0], p1_proto, p2_proto}), 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        chk(32'(er), 32'h1);
        $display("reset test done");
        apb(1'b1, `RSM_CTRL_OFS, 32'h0);
        u_host.move(1'b1, 30);
        chk(32'(run_mode), 32'h0);
        u_host.move(1'b0, 30);
        apb(1'b1, `RSM_CTRL_OFS, 32'h1);
        @(posedge sys_clk) minor <= 1'b1;
        @(posedge sys_clk) minor <= 1'b0;
        u_host.move(1'b1, 30);
        apb(1'b0, `RSM_STAT_OFS, 32'h0);
        chk(32'({run_mode, rd[5], rd[1:0]}), 32'hd);
        $display("switch test done");
        apb(1'b1, `RSM_PORT_OFS, 32'h2580_000a);
        wt(3);
        chk(32'({p1_proto, p2_proto}), 32'ha);
        u_host.move(1'b0, 30);
        chk(32'({run_mode, p1_proto, p2_proto}), 32'h0);
        apb(1'b0, `RSM_PORT_OFS, 32'h0);
        chk(rd, 32'h2580_000a);
        apb(1'b1, `RSM_PORT_OFS, 32'h2580_0005);
        need <= 2'h1;
        wt(3);
        chk(32'({p1_proto, p2_proto}), 32'h1);
        $display("port test done");
        apb(1'b1, `RSM_CTRL_OFS, 32'h3);
        mem_req <= 1'b1;
        wt(3);
        chk(32'(mem_ok), 32'h0);
        u_host.move(1'b1, 30);
        chk(32'({mem_ok, run_mode}), 32'h3);
        $display("protect test done");
        apb(1'b1, `RSM_CTRL_OFS, 32'h1);
        u_host.move(1'b0, 30);
        apb(1'b1, `RSM_IRQ_MASK_OFS, 32'h0);
        apb(1'b1, `RSM_IRQ_STAT_OFS, 32'h1f);
        @(posedge sys_clk) fatal <= 1'b1;
        @(posedge sys_clk) fatal <= 1'b0;
        wt(3);
        chk(32'({fault_led, run_mode, irq}), 32'h4);
        apb(1'b1, `RSM_IRQ_MASK_OFS, 32'h1f);
        wt(2);
        chk(32'(irq), 32'h1);
        u_host.move(1'b1, 30);
        a = run_led;
        wt(20);
        chk(32'(run_led), 32'(!a));
        wt(HOLD - 20);
        u_host.move(1'b0, HOLD + 30);
        u_host.move(1'b1, 20);
        chk(32'({run_mode, run_led, fault_led}), 32'h6);
        apb(1'b0, `RSM_IRQ_STAT_OFS, 32'h0);
        chk(32'(rd[4:1]), 32'hb);
        apb(1'b1, `RSM_IRQ_STAT_OFS, 32'h1f);
        wt(2);
        chk(32'(irq), 32'h0);
        $display("recovery test done");
        @(posedge sys_clk) fatal <= 1'b1;
        @(posedge sys_clk) fatal <= 1'b0;
        u_host.move(1'b0, 30);
        u_host.move(1'b1, WIN + 100);
        chk(32'({run_mode, run_led, fault_led}), 32'h1);
        apb(1'b0, `RSM_STAT_OFS, 32'h0);
        chk(32'(rd[1:0]), 32'h2);
        $display("expiry test done");
        apb(1'b1, `RSM_CTRL_OFS, 32'h9);
        wt(3);
        apb(1'b0, `RSM_STAT_OFS, 32'h0);
        chk(32'({fault_led, rd[5:4], rd[1:0]}), 32'h0);
        u_host.move(1'b0, 30);
        u_host.move(1'b1, 30);
        chk(32'(run_mode), 32'h1);
        apb(1'b1, `RSM_CTRL_OFS, 32'h5);
        wt(3);
        chk(32'(run_mode), 32'h0);
        apb(1'b0, `RSM_CTRL_OFS, 32'h0);
        chk(rd, 32'h5);
        $display("clear test done");
        tally_and_finish;
    end
endmodule // test_run_stop_mode_control
bind rsm_mode_ctrl rsm_chk #(.BLINK_CYC(BLINK_CYC)) u_rsm_chk (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_WR_REQ(MEM_WR_REQ),
    .MEM_WR_OK(MEM_WR_OK), .PROG_NEED(PROG_NEED),
    .PORT1_PROTO(PORT1_PROTO), .PORT2_PROTO(PORT2_PROTO),
    .P1_TX_INT(P1_TX_INT), .P1_TXD(P1_TXD), .P1_RXD(P1_RXD),
    .P1_RX_INT(P1_RX_INT), .FATAL_FAULT(FATAL_FAULT), .RUN_MODE(RUN_MODE),
    .RUN_LED(RUN_LED), .FAULT_LED(FAULT_LED));
